// ===== dv/lsi_chk.sv
`include "lsi_defs.svh"
// ==========================================
// port-level checks of the indicator block
module lsi_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_configured,
  input wire logic i_comm_active,
  input wire logic i_comm_error,
  input wire logic [1:0] i_link_up,
  input wire logic i_sync_select,
  input wire logic i_sync,
  input wire logic i_fw_running,
  input wire logic i_boot_active,
  input wire logic [`LSI_SHIFT_N-1:0] i_sync_serial_shift_io,
  input wire logic o_run_green,
  input wire logic o_run_red,
  input wire logic [1:0] o_link_led,
  input wire logic o_config_fault_indicator,
  input wire logic o_system_green,
  input wire logic o_system_yellow,
  input wire logic o_port0_link_out_n,
  input wire logic o_port1_link_out_n,
  input wire logic [`LSI_SHIFT_N-1:0] o_shift_out_lines
);
  logic live_q;
  logic live_d;
  // previous edge was a running one; skips the edge right after reset and frozen edges
  always_comb live_d = !i_rst && i_ce;
  always_ff @(posedge i_clk) live_q <= live_d;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  err_red_a: assert property (live_q && $past(i_comm_error) |-> o_run_red && !o_run_green)
    else $error("run led not red on comm error");
  comm_green_a: assert property (live_q && $past(i_configured && i_comm_active && !i_comm_error)
    |-> o_run_green && !o_run_red) else $error("run led not steady green");
  link_led_a: assert property (live_q |-> o_link_led == $past(i_link_up))
    else $error("link led does not follow link");
  link_pin_a: assert property (live_q |-> {o_port1_link_out_n, o_port0_link_out_n} == ~$past(i_link_up))
    else $error("link pins wrong");
  shift_copy_a: assert property (live_q |-> o_shift_out_lines == $past(i_sync_serial_shift_io))
    else $error("shift lines wrong");
  sync_route_a: assert property (live_q && $past(i_sync_select) |-> o_config_fault_indicator == $past(i_sync))
    else $error("sync not routed");
  fw_green_a: assert property (live_q && $past(i_fw_running) |-> o_system_green && !o_system_yellow)
    else $error("system led not green");
  boot_alt_a: assert property (live_q && $past(i_boot_active && !i_fw_running)
    |-> o_system_green != o_system_yellow) else $error("boot colours not exclusive");
  cov_err_c: cover property (o_run_red);
  cov_sync_c: cover property (i_sync_select && o_config_fault_indicator);
  cov_boot_c: cover property (i_boot_active && o_system_green);
endmodule : lsi_chk

bind lsi_top lsi_chk lsi_chk_inst (.*);

// ===== dv/lsi_top_tb.sv
`include "lsi_defs.svh"
// ==========================================
// directed bench; pattern counts are far too long to run, so only phase-start values are seen
module lsi_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst, i_ce, i_configured, i_comm_active, i_comm_error, i_unconf_blink_red;
  logic i_cfg_mode, i_cfg_error, i_module_error, i_sync_select, i_sync, i_fw_running, i_boot_active;
  logic [1:0] i_link_up, i_frame_seen, o_link_led, o_traffic_indicator;
  logic o_run_green, o_run_red, o_config_fault_indicator, o_system_green, o_system_yellow;
  logic o_port0_link_out_n, o_port1_link_out_n;
  logic [`LSI_SHIFT_N-1:0] i_sync_serial_shift_io, o_shift_out_lines;
  int errors = 0;
  int tests_run = 0;
  lsi_top lsi_top_inst (.*);
  // inputs move 1 ns after the edge so sampling never races
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // run led priorities; blink phase starts dark
  task automatic t_run;
    {i_configured, i_comm_active, i_comm_error} = 3'b111;
    step(2);
    chk({o_run_red, o_run_green}, 2'b10);
    {i_configured, i_comm_active, i_comm_error} = 3'b110;
    step(2);
    chk({o_run_red, o_run_green}, 2'b01);
    {i_configured, i_comm_active, i_comm_error} = 3'b100;
    step(2);
    chk({o_run_red, o_run_green}, 2'b00);
    {i_configured, i_comm_active, i_comm_error, i_unconf_blink_red} = 4'b0001;
    step(2);
    chk({o_run_red, o_run_green}, 2'b00);
  endtask : t_run
  // every link combination on leds and active-low pins
  task automatic t_link;
    for (int k = 0; k < 4; k++) begin
      i_link_up = 2'(k);
      step(2);
      chk({o_port1_link_out_n, o_port0_link_out_n, o_link_led}, {~2'(k), 2'(k)});
    end
  endtask : t_link
  // walking one over all shift lines
  task automatic t_shift;
    for (int k = 0; k < 16; k++) begin
      i_sync_serial_shift_io = 16'h0001 << k;
      step(2);
      chk(o_shift_out_lines, 16'h0001 << k);
    end
  endtask : t_shift
  // sync route overrides config mode, whose flash starts dark
  task automatic t_cf;
    {i_cfg_mode, i_sync_select, i_sync} = 3'b111;
    step(2);
    chk(o_config_fault_indicator, 1'b1);
    i_sync = 0;
    step(2);
    chk(o_config_fault_indicator, 1'b0);
    i_sync_select = 0;
    step(2);
    chk(o_config_fault_indicator, 1'b0);
    // module error beats config error; lfsr seed opens lit
    {i_module_error, i_cfg_error} = 2'h3;
    step(2);
    chk(o_config_fault_indicator, 1'b1);
    i_module_error = 0;
    step(2);
    chk(o_config_fault_indicator, 1'b0);
    {i_cfg_mode, i_cfg_error} = 2'h0;
  endtask : t_cf
  task automatic t_sys;
    {i_fw_running, i_boot_active} = 2'b11;
    step(2);
    chk({o_system_green, o_system_yellow}, 2'b10);
    {i_fw_running, i_boot_active} = 2'b01;
    step(2);
    chk({o_system_green, o_system_yellow}, 2'b10);
    i_boot_active = 0;
    step(2);
    chk({o_system_green, o_system_yellow}, 2'b00);
  endtask : t_sys
  // a frame arms the hold, but the shared flicker phase opens dark
  task automatic t_act;
    i_frame_seen = 2'h1;
    step(1);
    i_frame_seen = 2'h0;
    step(2);
    chk(o_traffic_indicator, 2'h0);
  endtask : t_act
  // mid-run reset drops every output to its idle level on the next clock edge
  task automatic t_rst;
    {i_fw_running, i_link_up, i_sync_serial_shift_io} = {1'b1, 2'h3, 16'hffff};
    step(2);
    chk({o_system_green, o_port1_link_out_n, o_port0_link_out_n, o_link_led}, 5'h13);
    i_rst = 1;
    step(2);
    chk({o_system_green, o_port1_link_out_n, o_port0_link_out_n, o_link_led}, 5'h0c);
    chk(o_shift_out_lines, 16'h0000);
    i_rst = 0;
    step(2);
    chk(o_shift_out_lines, 16'hffff);
    chk({o_system_green, o_link_led}, 3'h7);
  endtask : t_rst
  // clock enable low freezes every register, outputs included
  task automatic t_ce;
    i_ce = 0;
    {i_link_up, i_sync_serial_shift_io} = {2'h0, 16'h0000};
    step(3);
    chk(o_link_led, 2'h3);
    chk(o_shift_out_lines, 16'hffff);
    i_ce = 1;
    step(2);
    chk(o_link_led, 2'h0);
    chk(o_shift_out_lines, 16'h0000);
  endtask : t_ce
  initial begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end
  // hang guard, far beyond the under a hundred cycles needed
  initial begin
    #100us;
    errors++;
    conclude();
  end
  initial begin
    {i_rst, i_ce} = 2'b11;
    {i_configured, i_comm_active, i_comm_error, i_unconf_blink_red, i_cfg_mode, i_cfg_error,
      i_module_error, i_sync_select, i_sync, i_fw_running, i_boot_active, i_link_up, i_frame_seen,
      i_sync_serial_shift_io} = '0;
    step(8);
    i_rst = 0;
    step(1);
    t_run();
    t_link();
    t_shift();
    t_cf();
    t_sys();
    t_act();
    t_rst();
    t_ce();
    conclude();
  end
endmodule : lsi_top_tb

// ===== hw/lsi_defs.svh
`ifndef LSI_DEFS_SVH
`define LSI_DEFS_SVH
// Contract
// - steady on means always lit, steady off means always dark.
// - 2 Hz flash shows first colour 250 ms then second colour 250 ms.
// - flicker toggles at 10 Hz, 50 ms lit then 50 ms dark.
// - run/error blink toggles at 5 Hz, 100 ms lit then 100 ms dark.
// - configured without active communication blinks run/error green.
// - configured with active communication lights run/error green steadily.
// - each channel link indicator lit while link exists, dark otherwise.
// - each channel activity indicator flashes while frames move on it.
// - configuration mode flashes config/fault indicator red regularly.
// - module error flashes config/fault indicator red irregularly.
// - host command flag routes sync signal onto config/fault indicator.
// - sixteen shift output lines each drive one test indicator.
// - running firmware lights system indicator steadily green.
// - boot loader active blinks system indicator alternately green and yellow.
// - link of channel 0 and channel 1 on two separate outputs.

// ==========================================
// timing
`define LSI_CLK_HZ 100000000
`define LSI_FLASH_MS 250
`define LSI_FLICK_MS 50
`define LSI_BLINK_MS 100
`define LSI_CFG_MS 500
`define LSI_CFGERR_MS 125
`define LSI_ACT_HOLD_MS 50
`define LSI_MS_CYC (`LSI_CLK_HZ / 1000)
`define LSI_CNT_W 32
`define LSI_SHIFT_N 16

// ==========================================
// reset values
`define LSI_LFSR_SEED 8'h01
`endif

// ===== hw/lsi_pkg.sv
package lsi_pkg;
  // ==========================================
  // pattern selection for the config/fault indicator
  typedef enum logic [2:0] {
    LSI_CF_OFF,
    LSI_CF_SYNC,
    LSI_CF_MODERR,
    LSI_CF_CFGERR,
    LSI_CF_CFGMODE
  } lsi_cf_mode_t;
endpackage : lsi_pkg

// ===== hw/lsi_tick.sv
`include "lsi_defs.svh"
// ==========================================
// half-period toggle generator for one pattern
module lsi_tick #(
  parameter int unsigned HALF_MS = 250
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  output logic o_phase
);
  localparam logic [`LSI_CNT_W-1:0] HALF_CYC = `LSI_CNT_W'(HALF_MS * `LSI_MS_CYC);
  logic [`LSI_CNT_W-1:0] cnt_q, cnt_d;
  logic ph_q, ph_d;

  // count one half period, then flip the phase
  always_comb begin
    cnt_d = cnt_q + `LSI_CNT_W'(1);
    ph_d = ph_q;
    if (cnt_q == HALF_CYC - `LSI_CNT_W'(1)) begin
      cnt_d = '0;
      ph_d = ~ph_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= '0;
      ph_q <= 1'b0;
    end else if (i_ce) begin
      cnt_q <= cnt_d;
      ph_q <= ph_d;
    end
  end

  assign o_phase = ph_q;
endmodule : lsi_tick

// ===== hw/lsi_top.sv
`include "lsi_defs.svh"
// ==========================================
// front indicator pattern logic
module lsi_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_configured,
  input wire logic i_comm_active,
  input wire logic i_comm_error,
  input wire logic i_unconf_blink_red,
  input wire logic [1:0] i_link_up,
  input wire logic [1:0] i_frame_seen,
  input wire logic i_cfg_mode,
  input wire logic i_cfg_error,
  input wire logic i_module_error,
  input wire logic i_sync_select,
  input wire logic i_sync,
  input wire logic i_fw_running,
  input wire logic i_boot_active,
  input wire logic [`LSI_SHIFT_N-1:0] i_sync_serial_shift_io,
  output logic o_run_green,
  output logic o_run_red,
  output logic [1:0] o_link_led,
  output logic [1:0] o_traffic_indicator,
  output logic o_config_fault_indicator,
  output logic o_system_green,
  output logic o_system_yellow,
  output logic o_port0_link_out_n,
  output logic o_port1_link_out_n,
  output logic [`LSI_SHIFT_N-1:0] o_shift_out_lines
);
  // ==========================================
  // pattern phase generators
  logic ph_flash, ph_flick, ph_blink, ph_cfg, ph_cfgerr;

  // 2 Hz colour alternation for the system indicator during boot
  lsi_tick #(.HALF_MS(`LSI_FLASH_MS)) u_flash (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .o_phase(ph_flash)
  );
  // 10 Hz flicker, shared by both activity leds and the lfsr step
  lsi_tick #(.HALF_MS(`LSI_FLICK_MS)) u_flick (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .o_phase(ph_flick)
  );
  // 5 Hz blink for the run/error indicator
  lsi_tick #(.HALF_MS(`LSI_BLINK_MS)) u_blink (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .o_phase(ph_blink)
  );
  // slow regular flash while in configuration mode
  lsi_tick #(.HALF_MS(`LSI_CFG_MS)) u_cfg (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .o_phase(ph_cfg)
  );
  // faster regular flash, so a config error reads apart from config mode
  lsi_tick #(.HALF_MS(`LSI_CFGERR_MS)) u_cfgerr (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .o_phase(ph_cfgerr)
  );

  // ==========================================
  // irregular pattern: 8-bit lfsr stepped on each flicker edge
  logic [7:0] lfsr_q, lfsr_d;
  logic flick_prev_q, flick_prev_d;

  always_comb begin
    flick_prev_d = ph_flick;
    lfsr_d = lfsr_q;
    if (ph_flick != flick_prev_q) begin
      lfsr_d = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end
  end

  // nonzero seed: an all-zero lfsr would lock up and never flash
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lfsr_q <= `LSI_LFSR_SEED;
      flick_prev_q <= 1'b0;
    end else if (i_ce) begin
      lfsr_q <= lfsr_d;
      flick_prev_q <= flick_prev_d;
    end
  end

  // ==========================================
  // activity stretch: each frame restarts a hold so short bursts stay visible
  localparam logic [`LSI_CNT_W-1:0] ACT_CYC = `LSI_CNT_W'(`LSI_ACT_HOLD_MS * `LSI_MS_CYC);
  logic [1:0] act_busy;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_act
      // a lone one-cycle frame pulse holds busy for one flicker half; it lights only where that overlaps the lit flicker phase
      logic [`LSI_CNT_W-1:0] hold_q, hold_d;
      always_comb begin
        hold_d = hold_q;
        if (i_frame_seen[g]) begin
          hold_d = ACT_CYC;
        end else if (hold_q != '0) begin
          hold_d = hold_q - `LSI_CNT_W'(1);
        end
      end
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          hold_q <= '0;
        end else if (i_ce) begin
          hold_q <= hold_d;
        end
      end
      assign act_busy[g] = (hold_q != '0);
    end
  endgenerate

  // ==========================================
  // config/fault source selection; sync override first, then severity
  lsi_pkg::lsi_cf_mode_t cf_mode;
  always_comb begin
    if (i_sync_select) begin
      cf_mode = lsi_pkg::LSI_CF_SYNC;
    end else if (i_module_error) begin
      cf_mode = lsi_pkg::LSI_CF_MODERR;
    end else if (i_cfg_error) begin
      cf_mode = lsi_pkg::LSI_CF_CFGERR;
    end else if (i_cfg_mode) begin
      cf_mode = lsi_pkg::LSI_CF_CFGMODE;
    end else begin
      cf_mode = lsi_pkg::LSI_CF_OFF;
    end
  end

  // ==========================================
  // next output values
  logic run_g_d, run_r_d, cf_d, sys_g_d, sys_y_d;
  logic [1:0] link_d, act_d;

  always_comb begin
    // red beats green; unconfigured is dark unless red blink requested
    run_g_d = 1'b0;
    run_r_d = 1'b0;
    if (i_comm_error) begin
      run_r_d = 1'b1;
    end else if (!i_configured) begin
      run_r_d = i_unconf_blink_red & ph_blink;
    end else if (i_comm_active) begin
      run_g_d = 1'b1;
    end else begin
      run_g_d = ph_blink;
    end
    link_d = i_link_up;
    act_d = act_busy & {2{ph_flick}};
    // config/fault pattern per selected source
    case (cf_mode)
      lsi_pkg::LSI_CF_SYNC: cf_d = i_sync;
      lsi_pkg::LSI_CF_MODERR: cf_d = lfsr_q[0];
      lsi_pkg::LSI_CF_CFGERR: cf_d = ph_cfgerr;
      lsi_pkg::LSI_CF_CFGMODE: cf_d = ph_cfg;
      lsi_pkg::LSI_CF_OFF: cf_d = 1'b0;
      default: cf_d = 1'b0;
    endcase
    // firmware wins; boot loader alternates colours on the 2 Hz phase
    if (i_fw_running) begin
      sys_g_d = 1'b1;
      sys_y_d = 1'b0;
    end else if (i_boot_active) begin
      sys_g_d = ~ph_flash;
      sys_y_d = ph_flash;
    end else begin
      sys_g_d = 1'b0;
      sys_y_d = 1'b0;
    end
  end

  // ==========================================
  // output registers
  logic run_g_q, run_r_q, cf_q, sys_g_q, sys_y_q;
  logic [1:0] link_q, act_q;
  logic [`LSI_SHIFT_N-1:0] shift_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      run_g_q <= 1'b0;
      run_r_q <= 1'b0;
      cf_q <= 1'b0;
      sys_g_q <= 1'b0;
      sys_y_q <= 1'b0;
      link_q <= 2'h0;
      act_q <= 2'h0;
      shift_q <= 16'h0000;
    end else if (i_ce) begin
      run_g_q <= run_g_d;
      run_r_q <= run_r_d;
      cf_q <= cf_d;
      sys_g_q <= sys_g_d;
      sys_y_q <= sys_y_d;
      link_q <= link_d;
      act_q <= act_d;
      shift_q <= i_sync_serial_shift_io;
    end
  end

  assign o_run_green = run_g_q;
  assign o_run_red = run_r_q;
  assign o_link_led = link_q;
  assign o_traffic_indicator = act_q;
  assign o_config_fault_indicator = cf_q;
  assign o_system_green = sys_g_q;
  assign o_system_yellow = sys_y_q;
  // separate active-low link pins, one per channel
  assign o_port0_link_out_n = ~link_q[0];
  assign o_port1_link_out_n = ~link_q[1];
  assign o_shift_out_lines = shift_q;
endmodule : lsi_top
